/* File: rtl/sbc_status_flag_bank.sv */
// Sticky supply and thermal status flags read and cleared over serial.
`timescale 1ns/1ps
module sbc_status_flag_bank
  import sbc_status_pkg::*;
#(
  parameter logic [TIMER_W-1:0] SHORT_CYCLES_P = SHORT_CYCLES
) (
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     spiCsN,
  input  wire logic     spiSclk,
  input  wire logic     spiSdi,
  output logic          spiSdo,
  output logic          spiSdoOe,
  input  wire faultIn_s faultIn,
  input  wire sbcMode_e sbcMode,
  input  wire logic     mainRegOn,
  input  wire logic     chargePumpEnable,
  input  wire logic     loadPeakActive,
  input  wire logic     resetReleased,
  input  wire logic     softReset,
  input  wire logic     wdogMissEvent,
  input  wire logic     wdTriggerOk,
  input  wire logic     shut2StreakEnd,
  output logic          longRecoveryWait
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    linkState_e  link;
    logic [2:0]  csnSync;
    logic [2:0]  sclkSync;
    logic [1:0]  sdiSync;
    faultIn_s    faultMeta;
    faultIn_s    faultSync;
    logic        shut2Prev;
    logic [4:0]  bitCount;
    logic [15:0] frame;
    logic [7:0]  snapshot;
    logic [7:0]  supHi;
    logic [7:0]  supLo;
    logic [7:0]  therm;
    logic [1:0]  wdCount;
    logic [4:0]  shut2Count;
    logic        sdo;
    logic        sdoOe;
    logic        longWait;
  } state_s;

  state_s     st;
  state_s     next_st;
  logic       shortLong;
  logic       sclkRise;
  logic       sclkFall;
  logic       csnFall;
  logic       csnRise;
  logic       endFrame;
  logic       clearReq;
  logic [6:0] addr;
  logic [7:0] readData;
  logic [7:0] clrHi;
  logic [7:0] clrLo;
  logic [7:0] clrTh;
  logic [7:0] setHi;
  logic [7:0] setLo;
  logic [7:0] setTh;
  logic       battUvEn;
  logic       battOvEn;
  logic       stopExcept;
  logic       mainOffSleep;
  logic       mainUvEn;
  logic       shut2Rise;
  faultIn_s   fs;

  // ----------------------------------------------------------------
  // Short-to-ground qualifier
  // ----------------------------------------------------------------
  // persistence timing qualifier.
  persist_timer #(
    .LIMIT (SHORT_CYCLES_P)
  ) shortTimer (
    .clk     (clk),
    .rst     (rst),
    .cond    (mainRegOn && st.faultSync.mainBelowReset),
    .expired (shortLong)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Synchronise pins, run the frame, and update the flags.
  always_comb begin
    next_st = st;
    fs      = st.faultSync;

    // Two-stage synchronisers; the third csn/sclk stage is history.
    next_st.csnSync   = {st.csnSync[1:0], spiCsN};
    next_st.sclkSync  = {st.sclkSync[1:0], spiSclk};
    next_st.sdiSync   = {st.sdiSync[0], spiSdi};
    next_st.faultMeta = faultIn;
    next_st.faultSync = st.faultMeta;
    next_st.shut2Prev = fs.shut2;

    sclkRise = st.sclkSync[1] && !st.sclkSync[2];
    sclkFall = !st.sclkSync[1] && st.sclkSync[2];
    csnFall  = !st.csnSync[1] && st.csnSync[2];
    csnRise  = st.csnSync[1] && !st.csnSync[2];
    addr     = st.frame[6:0];

    // reserved and unmodelled bytes read zero.
    if (addr == ADDR_SUP_HI) begin
      readData = st.supHi & SUP_HI_MASK;
    end else if (addr == ADDR_SUP_LO) begin
      readData = st.supLo & SUP_LO_MASK;
    end else if (addr == ADDR_THERM) begin
      readData = st.therm & THERM_MASK;
    end else if (addr == ADDR_DEV) begin
      readData = {4'h0, st.wdCount, 2'h0};
    end else if (addr == ADDR_IDENT) begin
      readData = IDENT_VALUE;
    end else begin
      readData = 8'h00;
    end

    // only a full frame may clear.
    endFrame = csnRise && (st.link == LINK_SHIFT) &&
               (st.bitCount == FRAME_BITS);
    // mode bit picks read or clear.
    clearReq = endFrame && st.frame[MODE_BIT];
    // clear only the bits that were reported.
    clrHi = (clearReq && addr == ADDR_SUP_HI) ? st.snapshot : 8'h00;
    clrLo = (clearReq && addr == ADDR_SUP_LO) ? st.snapshot : 8'h00;
    clrTh = (clearReq && addr == ADDR_THERM) ? st.snapshot : 8'h00;

    case (st.link)
      LINK_IDLE: begin
        next_st.sdo   = 1'b0;
        next_st.sdoOe = 1'b0;
        if (csnFall) begin
          next_st.link     = LINK_SHIFT;
          next_st.bitCount = 5'h00;
          next_st.frame    = 16'h0000;
          next_st.sdoOe    = 1'b1;
        end
      end
      LINK_SHIFT: begin
        if (csnRise) begin
          next_st.link  = LINK_IDLE;
          next_st.sdo   = 1'b0;
          next_st.sdoOe = 1'b0;
        end else if (sclkRise && st.bitCount != FRAME_BITS) begin
          next_st.frame[st.bitCount[3:0]] = st.sdiSync[1];
          next_st.bitCount = st.bitCount + 5'h01;
          // capture the byte before any clear.
          if (st.bitCount == MODE_POS) begin
            next_st.snapshot = readData;
          end
        end else if (sclkFall) begin
          // data byte goes out in frame bits 8..15.
          if (st.bitCount >= DATA_FIRST &&
              st.bitCount != FRAME_BITS) begin
            next_st.sdo = st.snapshot[st.bitCount[2:0]];
          end else begin
            next_st.sdo = 1'b0;
          end
        end
      end
      default: begin
        next_st.link  = LINK_IDLE;
        next_st.sdoOe = 1'b0;
      end
    endcase

    // stop mode exceptions for battery monitoring.
    stopExcept = loadPeakActive || fs.mainPrewarn;
    // battery monitors need the main regulator.
    battUvEn = mainRegOn &&
               (sbcMode != MODE_STOP || stopExcept);
    // charge pump keeps overvoltage monitoring on.
    battOvEn = mainRegOn && (chargePumpEnable ||
               sbcMode != MODE_STOP || stopExcept);
    // no main overvoltage, undervoltage or short flags while asleep with main off.
    mainOffSleep = (sbcMode == MODE_SLEEP) && !mainRegOn;
    mainUvEn = !mainOffSleep && (shortLong ||
               sbcMode == MODE_NORMAL ||
               sbcMode == MODE_STOP ||
               (sbcMode == MODE_INIT && resetReleased));

    setHi             = 8'h00;
    setHi[HI_BATT_UV] = fs.battUv && battUvEn;
    setHi[HI_BATT_OV] = fs.battOv && battOvEn;
    setHi[HI_MAIN_OV] = fs.mainOv && !mainOffSleep;
    setHi[HI_PREWARN] = fs.mainPrewarn;

    setLo             = 8'h00;
    setLo[LO_AUX_OT]  = fs.auxOt;
    setLo[LO_AUX_UV]  = fs.auxUv;
    setLo[LO_MAIN_UV] = fs.mainBelowReset && mainUvEn;
    setLo[LO_SHORT]   = shortLong && !mainOffSleep;

    shut2Rise = fs.shut2 && !st.shut2Prev;
    if (shut2StreakEnd) begin
      next_st.shut2Count = 5'h00;
    end else if (shut2Rise && st.shut2Count != SHUT2_SAT) begin
      next_st.shut2Count = st.shut2Count + 5'h01;
    end
    next_st.longWait = st.shut2Count > SHUT2_STREAK;

    setTh             = 8'h00;
    setTh[TH_SAFE]    = st.shut2Count > SHUT2_STREAK;
    setTh[TH_SHUT2]   = fs.shut2;
    setTh[TH_SHUT1]   = fs.shut1;
    setTh[TH_PREWARN] = fs.heatWarn;

    // sticky flags: set wins over a same-cycle clear.
    // thermal flags hold after the condition ends.
    next_st.supHi = ((st.supHi & ~clrHi) | setHi) & SUP_HI_MASK;
    next_st.supLo = ((st.supLo & ~clrLo) | setLo) & SUP_LO_MASK;
    next_st.therm = ((st.therm & ~clrTh) | setTh) & THERM_MASK;

    // watchdog failure count, cleared by the device.
    if (wdTriggerOk) begin
      next_st.wdCount = 2'h0;
    end else if (wdogMissEvent && st.wdCount != WDOG_MISS_MAX) begin
      next_st.wdCount = st.wdCount + 2'h1;
    end

    // soft reset leaves all flag bytes at zero.
    if (softReset) begin
      next_st.supHi     = SUP_HI_RST;
      next_st.supLo     = SUP_LO_SOFT;
      next_st.therm     = THERM_RST;
      next_st.wdCount   = 2'h0;
      next_st.shut2Count = 5'h00;
      next_st.longWait  = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // power-on reset marks the power-on flag.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st          <= '0;
      st.link     <= LINK_IDLE;
      st.csnSync  <= 3'h7;
      st.supHi    <= SUP_HI_RST;
      st.supLo    <= SUP_LO_POR;
      st.therm    <= THERM_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from flip-flops.
  assign spiSdo           = st.sdo;
  assign spiSdoOe         = st.sdoOe;
  assign longRecoveryWait = st.longWait;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_reserved_zero: assert property (
    (st.supHi & ~SUP_HI_MASK) == 8'h00 &&
    (st.supLo & ~SUP_LO_MASK) == 8'h00 &&
    (st.therm & ~THERM_MASK) == 8'h00)
    else $error("Reserved status bit is set.");

  a_battuv_latch: assert property (
    battUvEn && fs.battUv && !softReset |=> st.supHi[HI_BATT_UV])
    else $error("Battery undervoltage not latched.");

  a_stop_uv_off: assert property (
    sbcMode == MODE_STOP && !loadPeakActive && !fs.mainPrewarn &&
    !st.supHi[HI_BATT_UV] |=> !st.supHi[HI_BATT_UV])
    else $error("Battery undervoltage set in stop mode.");

  a_pump_ov: assert property (
    mainRegOn && chargePumpEnable && fs.battOv && !softReset
    |=> st.supHi[HI_BATT_OV])
    else $error("Overvoltage missed with charge pump on.");

  a_flags_hold: assert property (
    !clearReq && !softReset
    |=> (st.therm & $past(st.therm)) == $past(st.therm) &&
        (st.supLo & $past(st.supLo)) == $past(st.supLo))
    else $error("Status flag dropped without a clear.");
  a_clear_byte: assert property (
    clearReq && addr == ADDR_THERM && setTh == 8'h00 &&
    !softReset |=> (st.therm & $past(st.snapshot)) == 8'h00)
    else $error("Clear access left thermal flags set.");
  a_read_only: assert property (
    endFrame && !st.frame[MODE_BIT] |-> clrHi == 8'h00 &&
    clrLo == 8'h00 && clrTh == 8'h00)
    else $error("Read access attempted to clear.");

  a_soft_zero: assert property (
    softReset ##1 (!softReset && fs == '0 && !shortLong)[*2]
    |-> st.supLo == SUP_LO_SOFT)
    else $error("Soft reset value is wrong.");

  a_sleep_block: assert property (
    mainOffSleep && !st.supLo[LO_SHORT] |=> !st.supLo[LO_SHORT])
    else $error("Short flag set while asleep.");

  a_restart_uv: assert property (
    sbcMode == MODE_RESTART && !shortLong &&
    !st.supLo[LO_MAIN_UV] |=> !st.supLo[LO_MAIN_UV])
    else $error("Main undervoltage updated in restart.");
  a_short_latch: assert property (
    shortLong && !mainOffSleep && !softReset
    |=> st.supLo[LO_SHORT])
    else $error("Short to ground not latched.");
  a_safe_state: assert property (
    st.shut2Count > SHUT2_STREAK && !softReset |=>
    st.therm[TH_SAFE] && longRecoveryWait)
    else $error("Safe state not latched after streak.");
  a_wd_range: assert property (
    wdTriggerOk |=> st.wdCount == 2'h0 && st.wdCount != 2'h3)
    else $error("Watchdog count not cleared.");

  a_oe_frame: assert property (
    csnFall && st.link == LINK_IDLE |=> spiSdoOe [*2])
    else $error("Output not enabled after select.");

  c_read_frame: cover property (endFrame && !st.frame[MODE_BIT]);
  c_clear_frame: cover property (clearReq && st.snapshot != 8'h00);
  c_short_seen: cover property ($rose(shortLong));
  c_safe_seen: cover property ($rose(st.therm[TH_SAFE]));

endmodule

/* File: rtl/sbc_status_pkg.sv */
// Constants, types and carriers shared by the status flag bank.
package sbc_status_pkg;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] DATA_FIRST = 5'h08;
  localparam logic [4:0] MODE_POS   = 5'h07;
  localparam int         MODE_BIT   = 7;

  // ----------------------------------------------------------------
  // Register addresses (7-bit)
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_SUP_HI  = 7'h40;
  localparam logic [6:0] ADDR_SUP_LO  = 7'h41;
  localparam logic [6:0] ADDR_THERM   = 7'h42;
  localparam logic [6:0] ADDR_DEV     = 7'h43;
  localparam logic [6:0] ADDR_BUS     = 7'h44;
  localparam logic [6:0] ADDR_WAKE_A  = 7'h46;
  localparam logic [6:0] ADDR_WAKE_B  = 7'h47;
  localparam logic [6:0] ADDR_WAKE_LV = 7'h48;
  localparam logic [6:0] ADDR_GPIO_OC = 7'h54;
  localparam logic [6:0] ADDR_GPIO_OL = 7'h55;
  localparam logic [6:0] ADDR_SEL_WK  = 7'h70;
  localparam logic [6:0] ADDR_SEL_ERR = 7'h71;
  localparam logic [6:0] ADDR_CDR_A   = 7'h72;
  localparam logic [6:0] ADDR_CDR_B   = 7'h73;
  localparam logic [6:0] ADDR_IDENT   = 7'h7e;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int HI_BATT_UV   = 6;
  localparam int HI_BATT_OV   = 5;
  localparam int HI_MAIN_OV   = 1;
  localparam int HI_PREWARN   = 0;
  localparam int LO_POR       = 7;
  localparam int LO_AUX_OT    = 4;
  localparam int LO_AUX_UV    = 3;
  localparam int LO_SHORT     = 2;
  localparam int LO_MAIN_UV   = 0;
  localparam int TH_SAFE      = 3;
  localparam int TH_SHUT2     = 2;
  localparam int TH_SHUT1     = 1;
  localparam int TH_PREWARN   = 0;
  localparam int DEV_WD_LSB   = 2;

  // ----------------------------------------------------------------
  // Implemented-bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SUP_HI_MASK   = 8'h63;
  localparam logic [7:0] SUP_LO_MASK   = 8'h9d;
  localparam logic [7:0] THERM_MASK    = 8'h0f;
  localparam logic [7:0] SUP_HI_RST    = 8'h00;
  localparam logic [7:0] SUP_LO_POR    = 8'h80;
  localparam logic [7:0] SUP_LO_SOFT   = 8'h00;
  localparam logic [7:0] THERM_RST     = 8'h00;
  // Identification value is arbitrary.
  localparam logic [7:0] IDENT_VALUE   = 8'h5a;

  // ----------------------------------------------------------------
  // Counters and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] WDOG_MISS_MAX = 2'h2;
  localparam logic [4:0] SHUT2_STREAK  = 5'h10;
  localparam logic [4:0] SHUT2_SAT     = 5'h1f;
  localparam int         LONG_WAIT_S   = 60;
  localparam int         CLK_FREQ_MHZ  = 125;
  localparam int         SHORT_TIME_US = 2000;
  localparam int         TIMER_W       = 18;
  localparam logic [TIMER_W-1:0] SHORT_CYCLES =
    TIMER_W'(SHORT_TIME_US * CLK_FREQ_MHZ);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    MODE_INIT     = 6'h01,
    MODE_NORMAL   = 6'h02,
    MODE_STOP     = 6'h04,
    MODE_SLEEP    = 6'h08,
    MODE_RESTART  = 6'h10,
    MODE_FAILSAFE = 6'h20
  } sbcMode_e;

  typedef enum logic [1:0] {
    LINK_IDLE  = 2'h1,
    LINK_SHIFT = 2'h2
  } linkState_e;

  typedef struct packed {
    logic battUv;
    logic battOv;
    logic mainOv;
    logic mainPrewarn;
    logic auxOt;
    logic auxUv;
    logic mainBelowReset;
    logic shut2;
    logic shut1;
    logic heatWarn;
  } faultIn_s;

endpackage

/* File: rtl/persist_timer.sv */
// Qualifier that reports a condition held for a set number of cycles.
`timescale 1ns/1ps
module persist_timer
  import sbc_status_pkg::*;
#(
  parameter logic [TIMER_W-1:0] LIMIT = SHORT_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic cond,
  output logic      expired
);

  typedef struct packed {
    logic [TIMER_W-1:0] count;
    logic               expired;
  } timer_s;

  timer_s st;
  timer_s next_st;

  // Count while the condition holds; saturate at the limit.
  always_comb begin
    next_st = st;
    if (!cond) begin
      next_st.count   = '0;
      next_st.expired = 1'b0;
    end else begin
      if (st.count != LIMIT) begin
        next_st.count = st.count + 1'b1;
      end
      next_st.expired = (st.count == LIMIT);
    end
  end

  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign expired = st.expired;

endmodule

/* File: verif/spi_master_model.sv */
// Serial master that reads and clears bytes of the status flag bank.
`timescale 1ns/1ps
module spi_master_model (
  input  wire logic clk,
  input  wire logic spiSdo,
  input  wire logic spiSdoOe,
  output logic      spiCsN,
  output logic      spiSclk,
  output logic      spiSdi
);
  // Idle link: deselected, serial clock parked low.
  initial begin
    spiCsN  = 1'b1;
    spiSclk = 1'b0;
    spiSdi  = 1'b0;
  end

  // Lets n clock edges pass and steps just past the last one.
  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Frame transfer
  // ----------------------------------------------------------------
  // frame layout
  // mode bit carried
  // Shifts nbits LSB first, 64 ns serial period, sampling on rising
  // edges; the data byte seen on the output is handed back.
  task automatic xfer(input  logic [15:0] frame,
                      input  int          nbits,
                      output logic [7:0]  rdata);
    logic [15:0] got;
    got = 16'h0000;
    edges(1);
    spiCsN = 1'b0;
    edges(4);
    for (int i = 0; i < nbits; i++) begin
      spiSdi = frame[i];
      edges(4);
      spiSclk = 1'b1;
      if (i < 16) begin
        got[i] = spiSdoOe ? spiSdo : 1'bx; // Disabled output is unknown.
      end
      edges(4);
      spiSclk = 1'b0;
    end
    edges(4);
    spiCsN = 1'b1;
    // A released data line must not look like a held value.
    spiSdi = ~spiSdi;
    edges(8);
    rdata = got[15:8];
  endtask
endmodule

/* File: verif/sbc_status_flag_bank_test.sv */
// Self-checking bench for the sticky status flag bank.
`timescale 1ns/1ps
module sbc_status_flag_bank_test;
  import sbc_status_pkg::*;
  localparam logic [TIMER_W-1:0] SHORT_SMALL = TIMER_W'(20);
  logic        clk, rst, spiCsN, spiSclk, spiSdi, spiSdo, spiSdoOe;
  logic        mainRegOn, chargePumpEnable, loadPeakActive;
  logic        resetReleased, softReset, wdogMissEvent, wdTriggerOk;
  logic        shut2StreakEnd, longRecoveryWait;
  faultIn_s    faultIn, f;
  sbcMode_e    sbcMode;
  logic [15:0] lfsr;
  logic [7:0]  rd;
  int          errTotal, cmpCount;

  sbc_status_flag_bank #(.SHORT_CYCLES_P(SHORT_SMALL)) i_sbc_status_flag_bank (
    .clk(clk), .rst(rst), .spiCsN(spiCsN), .spiSclk(spiSclk),
    .spiSdi(spiSdi), .spiSdo(spiSdo), .spiSdoOe(spiSdoOe),
    .faultIn(faultIn), .sbcMode(sbcMode), .mainRegOn(mainRegOn),
    .chargePumpEnable(chargePumpEnable), .loadPeakActive(loadPeakActive),
    .resetReleased(resetReleased), .softReset(softReset),
    .wdogMissEvent(wdogMissEvent), .wdTriggerOk(wdTriggerOk),
    .shut2StreakEnd(shut2StreakEnd), .longRecoveryWait(longRecoveryWait));

  spi_master_model i_spi_master_model (
    .clk(clk), .spiSdo(spiSdo), .spiCsN(spiCsN), .spiSclk(spiSclk),
    .spiSdi(spiSdi), .spiSdoOe(spiSdoOe));

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Pseudo-random sequence, fixed start for repeatable runs.
  function automatic logic [15:0] nextRand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected bytes for a set of released faults.
  function automatic logic [7:0] hiExp(input faultIn_s x);
    return {1'b0, x.battUv, x.battOv, 3'h0, x.mainOv, x.mainPrewarn};
  endfunction
  function automatic logic [7:0] loExp(input faultIn_s x);
    return {3'h0, x.auxOt, x.auxUv, 3'h0};
  endfunction
  function automatic logic [7:0] thExp(input faultIn_s x);
    return {5'h00, x.shut2, x.shut1, x.heatWarn};
  endfunction

  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic results();
    if (errTotal == 0 && cmpCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    cmpCount++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One full frame with random ignored data; compares the returned byte.
  task automatic rdChk(input logic [6:0] a, input logic clr,
                       input logic [7:0] exp);
    lfsr = nextRand(lfsr);
    i_spi_master_model.xfer({lfsr[7:0], clr, a}, 16, rd);
    chk8(rd, exp);
  endtask

  // Holds a fault level for some cycles, then lets the flags settle.
  task automatic hit(input faultIn_s x, input int hold);
    faultIn = x;
    edges(hold);
    faultIn = '0;
    edges(6);
  endtask

  // Applies a fault under one operating state, then clears and compares.
  task automatic modeCase(input sbcMode_e m, input logic on,
                          input logic pk, input logic cp,
                          input logic [9:0] x, input int hold,
                          input logic [6:0] a, input logic [7:0] exp);
    sbcMode = m;
    mainRegOn = on;
    loadPeakActive = pk;
    chargePumpEnable = cp;
    edges(2);
    hit(faultIn_s'(x), hold);
    sbcMode = MODE_NORMAL;
    mainRegOn = 1'b1;
    loadPeakActive = 1'b0;
    chargePumpEnable = 1'b0;
    rdChk(a, 1'b1, exp);
  endtask

  // Cuts a hung run short.
  initial begin
    #400000;
    errTotal++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    faultIn = '0;
    sbcMode = MODE_NORMAL;
    {mainRegOn, resetReleased} = 2'h3;
    {chargePumpEnable, loadPeakActive, softReset} = 3'h0;
    {wdogMissEvent, wdTriggerOk, shut2StreakEnd} = 3'h0;
    lfsr = 16'h003a;
    errTotal = 0;
    cmpCount = 0;
    edges(8);
    rst = 1'b0;
    edges(4);
    chk1(spiSdoOe, 1'b0);
    rdChk(ADDR_SUP_LO, 1'b0, SUP_LO_POR);
    rdChk(ADDR_SUP_LO, 1'b1, SUP_LO_POR);
    rdChk(ADDR_SUP_LO, 1'b0, 8'h00);
    rdChk(ADDR_SUP_HI, 1'b0, SUP_HI_RST);
    rdChk(ADDR_THERM, 1'b0, THERM_RST);
    rdChk(ADDR_IDENT, 1'b0, IDENT_VALUE);
    rdChk(7'h45, 1'b1, 8'h00);
    repeat (6) begin
      lfsr = nextRand(lfsr);
      f = faultIn_s'({lfsr[9:4], 1'b0, 1'b0, lfsr[1:0]});
      hit(f, 4);
      rdChk(ADDR_SUP_HI, 1'b0, hiExp(f));
      rdChk(ADDR_SUP_HI, 1'b1, hiExp(f));
      rdChk(ADDR_SUP_LO, 1'b1, loExp(f));
      rdChk(ADDR_THERM, 1'b1, thExp(f));
      rdChk(ADDR_SUP_HI, 1'b0, 8'h00);
    end
    modeCase(MODE_STOP, 1, 0, 0, 10'h200, 4, ADDR_SUP_HI, 8'h00);
    modeCase(MODE_STOP, 1, 1, 0, 10'h200, 4, ADDR_SUP_HI, 8'h40);
    modeCase(MODE_STOP, 1, 0, 1, 10'h100, 4, ADDR_SUP_HI, 8'h20);
    modeCase(MODE_STOP, 1, 0, 0, 10'h100, 4, ADDR_SUP_HI, 8'h00);
    modeCase(MODE_NORMAL, 0, 0, 0, 10'h200, 4, ADDR_SUP_HI, 8'h00);
    modeCase(MODE_SLEEP, 0, 0, 0, 10'h080, 4, ADDR_SUP_HI, 8'h00);
    modeCase(MODE_RESTART, 1, 0, 0, 10'h008, 4, ADDR_SUP_LO, 8'h00);
    resetReleased = 1'b0;
    modeCase(MODE_INIT, 1, 0, 0, 10'h008, 4, ADDR_SUP_LO, 8'h00);
    resetReleased = 1'b1;
    modeCase(MODE_INIT, 1, 0, 0, 10'h008, 4, ADDR_SUP_LO, 8'h01);
    modeCase(MODE_NORMAL, 1, 0, 0, 10'h008, 4, ADDR_SUP_LO, 8'h01);
    modeCase(MODE_NORMAL, 1, 0, 0, 10'h008, 30, ADDR_SUP_LO, 8'h05);
    hit(faultIn_s'(10'h020), 4);
    i_spi_master_model.xfer({8'h00, 1'b1, ADDR_SUP_LO}, 8, rd);
    chk1(spiSdoOe, 1'b0);
    rdChk(ADDR_SUP_LO, 1'b1, 8'h10);
    for (int i = 1; i <= 17; i++) begin
      hit(faultIn_s'(10'h004), 4);
      if (i == 16) begin
        chk1(longRecoveryWait, 1'b0);
      end
    end
    chk1(longRecoveryWait, 1'b1);
    rdChk(ADDR_THERM, 1'b1, 8'h0c);
    shut2StreakEnd = 1'b1;
    edges(1);
    shut2StreakEnd = 1'b0;
    edges(3);
    chk1(longRecoveryWait, 1'b0);
    repeat (3) begin
      wdogMissEvent = 1'b1;
      edges(1);
      wdogMissEvent = 1'b0;
      edges(2);
    end
    rdChk(ADDR_DEV, 1'b1, {4'h0, WDOG_MISS_MAX, 2'h0});
    rdChk(ADDR_DEV, 1'b0, {4'h0, WDOG_MISS_MAX, 2'h0});
    wdTriggerOk = 1'b1;
    edges(1);
    wdTriggerOk = 1'b0;
    edges(3);
    rdChk(ADDR_DEV, 1'b0, 8'h00);
    hit(faultIn_s'(10'h001), 4);
    softReset = 1'b1;
    edges(1);
    softReset = 1'b0;
    edges(3);
    rdChk(ADDR_SUP_LO, 1'b0, SUP_LO_SOFT);
    rdChk(ADDR_THERM, 1'b0, 8'h00);
    rst = 1'b1;
    edges(2);
    rst = 1'b0;
    edges(4);
    rdChk(ADDR_SUP_LO, 1'b0, SUP_LO_POR);
    results();
  end
endmodule
